/* File: usbic_pkg.sv */
// usbic_pkg: constants and carrier types for the usb interrupt enable,
// device address and endpoint selector block.
// assumes an 8-bit special-function-register space on the cpu side.
package usbic_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register offsets in the special-function-register space
	localparam logic [7:0] ADDR_EVT_FLAGS = 8'hbd; // usb event flags
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hbe; // usb_global_irq_mask
	localparam logic [7:0] ADDR_DEV_ADDR = 8'hc6; // usb_device_address
	localparam logic [7:0] ADDR_EP_SEL = 8'hc7; // endpoint_selector
	localparam logic [7:0] ADDR_EP_FIFO = 8'hcf; // selected_endpoint_fifo_data
	localparam logic [7:0] ADDR_EP_CTRL = 8'hd4; // selected_endpoint_control
	localparam logic [7:0] ADDR_EP_CNT_LO = 8'he2; // selected_byte_count_low
	localparam logic [7:0] ADDR_EP_CNT_HI = 8'he3; // selected_byte_count_high

	////////////////////////////////////////////////////////////////////////////
	// field positions and widths; wake, eor, sof and suspend are shared by the event flags and the mask
	localparam int BIT_WAKE = 5; // wake cpu
	localparam int BIT_EOR = 4; // end of bus reset
	localparam int BIT_SOF = 3; // start of frame
	localparam int BIT_SUSP = 0; // suspend
	localparam int BIT_FILTER_EN = 7; // address_filter_enable
	localparam int ADDR_W = 7; // device_address_field width
	localparam int EP_W = 4; // endpoint_number_field width

	// writable bits; all others are reserved and read as zero
	localparam logic [7:0] IRQ_MASK_LIVE = 8'h39;
	localparam logic [7:0] EP_SEL_LIVE = 8'h0f;

	// reset values
	localparam logic [7:0] IRQ_MASK_RST = 8'h10;
	localparam logic [7:0] DEV_ADDR_RST = 8'h00;
	localparam logic [7:0] EP_SEL_RST = 8'h00;
	localparam logic [7:0] EVT_FLAGS_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// timing: bus idle (j state) time that means suspend
	localparam int CLK_KHZ = 50000; // mclk in khz
	localparam int SUSPEND_IDLE_MS = 3; // idle time in ms
	localparam int SUSPEND_IDLE_CYC = SUSPEND_IDLE_MS * CLK_KHZ; // least time

	////////////////////////////////////////////////////////////////////////////
	// which per-endpoint register an access is steered to
	typedef enum logic [1:0] {
		EPREG_FIFO,
		EPREG_CNT_LO,
		EPREG_CNT_HI,
		EPREG_CTRL
	} usbic_epreg_t;

	// one access forwarded to the selected endpoint's storage
	typedef struct packed {
		logic rd;
		logic wr;
		logic [EP_W-1:0] ep;
		usbic_epreg_t regsel;
		logic [7:0] wdata;
	} usbic_epreq_t;

	// hardware events from the serial interface engine, one-cycle pulses
	typedef struct packed {
		logic wake;
		logic eor;
		logic sof;
	} usbic_evt_t;

endpackage

/* File: usbic_idle_det.sv */
// usbic_idle_det: counts cycles of continuous bus idle and pulses once
// when the suspend time has been reached.
// assumes bus_idle is synchronous to mclk and already glitch free.
`timescale 1ns/100ps
module usbic_idle_det #(
	parameter int IDLE_CYCLES = usbic_pkg::SUSPEND_IDLE_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	// bus state
	input wire logic bus_idle,
	// result
	output logic suspend_pulse
);

	localparam int CW = $clog2(IDLE_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(IDLE_CYCLES - 1);

	logic [CW-1:0] cnt_r; // idle cycles seen so far
	logic fired_r; // suspend already reported for this idle period

	////////////////////////////////////////////////////////////////////////////
	// any non-idle cycle restarts the count; one report per idle period,
	// so a long suspend does not flood the flag with repeated sets
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			fired_r <= 1'b0;
			suspend_pulse <= 1'b0;
		end else if (ce) begin
			suspend_pulse <= 1'b0;
			if (!bus_idle) begin
				cnt_r <= '0;
				fired_r <= 1'b0;
			end else if (!fired_r) begin
				if (cnt_r == LAST) begin
					fired_r <= 1'b1;
					suspend_pulse <= 1'b1;
				end else begin
					cnt_r <= cnt_r + CW'(1);
				end
			end
		end
	end

endmodule

/* File: usbic_ctrl.sv */
// usbic_ctrl: usb global interrupt mask, event flags, device address with
// address filter, and endpoint selector that steers per-endpoint accesses.
// assumes a cpu special-function-register port synchronous to mclk, and an
// external per-endpoint register bank that answers a forwarded read in the
// same cycle its request is presented.
`timescale 1ns/100ps
module usbic_ctrl #(
	parameter int IDLE_CYCLES = usbic_pkg::SUSPEND_IDLE_CYC,
	parameter int NUM_EP = 7
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	// cpu register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	output logic sfr_rvalid,
	// usb events from the serial interface engine
	input wire usbic_pkg::usbic_evt_t usb_evt,
	input wire logic usb_bus_reset,
	input wire logic usb_bus_idle,
	// received token address
	input wire logic tok_valid,
	input wire logic [6:0] tok_addr,
	output logic tok_accept,
	output logic tok_reject,
	// per-endpoint register bank
	output usbic_pkg::usbic_epreq_t ep_req,
	input wire logic [7:0] ep_rdata,
	output logic [3:0] ep_selected,
	// interrupt to the cpu
	output logic usb_irq
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// keep only live bits so reserved positions never store a one
	function automatic logic [7:0] live_bits(input logic [7:0] v, input logic [7:0] keep);
		return v & keep;
	endfunction

	// true when the address names one of the per-endpoint registers
	function automatic logic is_ep_addr(input logic [7:0] a);
		return (a == usbic_pkg::ADDR_EP_FIFO) || (a == usbic_pkg::ADDR_EP_CTRL) ||
			(a == usbic_pkg::ADDR_EP_CNT_LO) || (a == usbic_pkg::ADDR_EP_CNT_HI);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// reset release: asserted at once, released through two flops
	logic rst_s1_r; // first stage, read only by the second
	logic rst_n; // synchronised reset for the rest of the design

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [7:0] irq_mask_r; // usb_global_irq_mask
	logic [7:0] evt_flags_r; // sticky event flags
	logic [7:0] evt_flags_nxt;
	logic filter_en_r; // address_filter_enable
	logic [6:0] dev_addr_r; // device_address_field
	logic [3:0] ep_sel_r; // endpoint_number_field
	logic ep_rd_pend_r; // forwarded read awaiting bank data
	logic suspend_pulse; // from the idle detector
	logic [7:0] set_vec; // hardware sets this cycle
	logic wr_flags; // cpu writes the flag register
	usbic_pkg::usbic_epreg_t regsel; // decoded endpoint register

	assign ep_selected = ep_sel_r;

	////////////////////////////////////////////////////////////////////////////
	// suspend detection on long bus idle
	usbic_idle_det #(
		.IDLE_CYCLES(IDLE_CYCLES)
	) u_idle (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.bus_idle(usb_bus_idle),
		.suspend_pulse(suspend_pulse)
	);

	////////////////////////////////////////////////////////////////////////////
	// global interrupt mask; reserved bits are dropped on write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_r <= usbic_pkg::IRQ_MASK_RST;
		end else if (ce && sfr_wr && sfr_addr == usbic_pkg::ADDR_IRQ_MASK) begin
			irq_mask_r <= live_bits(sfr_wdata, usbic_pkg::IRQ_MASK_LIVE);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// event flags: hardware sets, software clears by writing zero
	always_comb begin
		set_vec = '0;
		set_vec[usbic_pkg::BIT_WAKE] = usb_evt.wake;
		set_vec[usbic_pkg::BIT_EOR] = usb_evt.eor;
		set_vec[usbic_pkg::BIT_SOF] = usb_evt.sof;
		set_vec[usbic_pkg::BIT_SUSP] = suspend_pulse;
	end

	assign wr_flags = sfr_wr && sfr_addr == usbic_pkg::ADDR_EVT_FLAGS;

	// a set arriving with the clear wins, so no event is lost
	always_comb begin
		evt_flags_nxt = evt_flags_r;
		if (wr_flags) begin
			evt_flags_nxt = evt_flags_r & sfr_wdata;
		end
		evt_flags_nxt = live_bits(evt_flags_nxt | set_vec, usbic_pkg::IRQ_MASK_LIVE);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			evt_flags_r <= usbic_pkg::EVT_FLAGS_RST;
		end else if (ce) begin
			evt_flags_r <= evt_flags_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt: any flag whose enable is set; registered for a clean output
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			usb_irq <= 1'b0;
		end else if (ce) begin
			usb_irq <= |(evt_flags_r & irq_mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// device address and filter enable; bus reset clears the address
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			filter_en_r <= usbic_pkg::DEV_ADDR_RST[usbic_pkg::BIT_FILTER_EN];
			dev_addr_r <= usbic_pkg::DEV_ADDR_RST[6:0];
		end else if (ce) begin
			if (usb_bus_reset) begin
				// bus reset beats a same-cycle cpu write: the host expects zero
				dev_addr_r <= usbic_pkg::DEV_ADDR_RST[6:0];
			end else if (sfr_wr && sfr_addr == usbic_pkg::ADDR_DEV_ADDR) begin
				dev_addr_r <= sfr_wdata[6:0];
			end
			if (sfr_wr && sfr_addr == usbic_pkg::ADDR_DEV_ADDR) begin
				filter_en_r <= sfr_wdata[usbic_pkg::BIT_FILTER_EN];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// token address filter; one result pulse per token
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tok_accept <= 1'b0;
			tok_reject <= 1'b0;
		end else if (ce) begin
			tok_accept <= 1'b0;
			tok_reject <= 1'b0;
			if (tok_valid) begin
				if (!filter_en_r || tok_addr == dev_addr_r) begin
					tok_accept <= 1'b1;
				end else begin
					tok_reject <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// endpoint selector; numbers above six are stored but have no bank
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ep_sel_r <= usbic_pkg::EP_SEL_RST[3:0];
		end else if (ce && sfr_wr && sfr_addr == usbic_pkg::ADDR_EP_SEL) begin
			ep_sel_r <= 4'(live_bits(sfr_wdata, usbic_pkg::EP_SEL_LIVE));
		end
	end

	// map the cpu address onto the per-endpoint register kind
	always_comb begin
		unique case (sfr_addr)
			usbic_pkg::ADDR_EP_CNT_LO: regsel = usbic_pkg::EPREG_CNT_LO;
			usbic_pkg::ADDR_EP_CNT_HI: regsel = usbic_pkg::EPREG_CNT_HI;
			usbic_pkg::ADDR_EP_CTRL: regsel = usbic_pkg::EPREG_CTRL;
			default: regsel = usbic_pkg::EPREG_FIFO;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// forward endpoint accesses, tagged with the selected number;
	// selections at or above NUM_EP are not forwarded, since no bank exists
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ep_req <= '0;
		end else if (ce) begin
			ep_req.rd <= 1'b0;
			ep_req.wr <= 1'b0;
			if (is_ep_addr(sfr_addr) && 32'(ep_sel_r) < NUM_EP) begin
				ep_req.rd <= sfr_rd;
				ep_req.wr <= sfr_wr;
				ep_req.ep <= ep_sel_r;
				ep_req.regsel <= regsel;
				ep_req.wdata <= sfr_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read path: own registers answer next cycle, endpoint reads two later
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata <= '0;
			sfr_rvalid <= 1'b0;
			ep_rd_pend_r <= 1'b0;
		end else if (ce) begin
			sfr_rvalid <= 1'b0;
			ep_rd_pend_r <= ep_req.rd;
			if (ep_rd_pend_r) begin
				sfr_rdata <= ep_rdata;
				sfr_rvalid <= 1'b1;
			end else if (sfr_rd && !is_ep_addr(sfr_addr)) begin
				sfr_rvalid <= 1'b1;
				unique case (sfr_addr)
					usbic_pkg::ADDR_IRQ_MASK: sfr_rdata <= irq_mask_r;
					usbic_pkg::ADDR_EVT_FLAGS: sfr_rdata <= evt_flags_r;
					usbic_pkg::ADDR_DEV_ADDR: sfr_rdata <= {filter_en_r, dev_addr_r};
					usbic_pkg::ADDR_EP_SEL: sfr_rdata <= {4'h0, ep_sel_r};
					default: sfr_rdata <= 8'h00; // unmapped reads zero
				endcase
			end else if (sfr_rd && 32'(ep_sel_r) >= NUM_EP) begin
				// no bank behind this selection: answer zero at once
				sfr_rdata <= 8'h00;
				sfr_rvalid <= 1'b1;
			end
		end
	end

	// the bank answers a forwarded endpoint read on ep_rdata in the cycle ep_req.rd is high;
	// sampling it one cycle later relies on the bank holding it steady
	// for the one cycle after the request, which it does through its hold flag

endmodule

/* File: usbic_ctrl_props.sv */
// usbic_ctrl_props: port-level checks for usbic_ctrl.
// assumes one clock domain and one access per cycle on the register port.
`timescale 1ns/100ps
module usbic_ctrl_props #(
	parameter int IDLE_CYCLES = usbic_pkg::SUSPEND_IDLE_CYC,
	parameter int NUM_EP = 7
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	// register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_rvalid,
	// usb side
	input wire usbic_pkg::usbic_evt_t usb_evt,
	input wire logic usb_bus_reset,
	input wire logic usb_bus_idle,
	input wire logic tok_valid,
	input wire logic tok_accept,
	input wire logic tok_reject,
	// endpoint bank and interrupt
	input wire usbic_pkg::usbic_epreq_t ep_req,
	input wire logic [7:0] ep_rdata,
	input wire logic [3:0] ep_selected,
	input wire logic usb_irq
);
	////////////////////////////////////////////////////////////////////////////
	// all checks share the one clock and the raw reset
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	chk_tok_one_reply: assert property (ce && tok_valid |=> $onehot({tok_accept, tok_reject}))
		else $error("token got no single verdict");
	chk_tok_has_cause: assert property (tok_accept || tok_reject |-> $past(ce)
		&& $past(tok_valid)) else $error("token verdict without token");
	// endpoint read must carry the selector seen when the read was taken
	chk_ep_forward: assert property (ce && sfr_rd && sfr_addr == usbic_pkg::ADDR_EP_FIFO
		&& ep_selected < NUM_EP |=> ep_req.rd && ep_req.ep == $past(ep_selected)
		&& ep_req.regsel == usbic_pkg::EPREG_FIFO) else $error("endpoint read misrouted");
	// bank data is taken one cycle after the forwarded pulse, shown one later
	chk_ep_answer: assert property (ep_req.rd |=> ##1 sfr_rvalid
		&& sfr_rdata == $past(ep_rdata)) else $error("endpoint data not returned");
	chk_rvalid_cause: assert property (sfr_rvalid |-> $past(ce) && $past(sfr_rd)
		|| $past(ep_req.rd, 2)) else $error("read answer without read");
	chk_mask_rsvd: assert property (ce && sfr_rd && sfr_addr == usbic_pkg::ADDR_IRQ_MASK
		|=> sfr_rvalid && (sfr_rdata & ~usbic_pkg::IRQ_MASK_LIVE) == 8'h00)
		else $error("mask reserved bits not zero");
	chk_sel_mirror: assert property (ce && sfr_rd && sfr_addr == usbic_pkg::ADDR_EP_SEL
		|=> sfr_rdata == {4'h0, ep_selected}) else $error("selector readback mismatch");
	// an interrupt only rises after an event, a suspend idle or a register write
	chk_irq_cause: assert property ($rose(usb_irq) |-> $past(usb_evt, 2) != 3'b000
		|| $past(sfr_wr, 2) || $past(usb_bus_idle, 3)) else $error("interrupt without cause");
	chk_irq_masked: assert property (ce && sfr_wr && sfr_addr == usbic_pkg::ADDR_IRQ_MASK
		&& sfr_wdata == 8'h00 |=> ##1 !usb_irq) else $error("interrupt survives zero mask");
	chk_addr_busrst: assert property (ce && usb_bus_reset ##1 ce && sfr_rd
		&& sfr_addr == usbic_pkg::ADDR_DEV_ADDR |=> sfr_rdata[6:0] == 7'h00)
		else $error("address kept over bus reset");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind usbic_ctrl usbic_ctrl_props #(.IDLE_CYCLES(IDLE_CYCLES), .NUM_EP(NUM_EP)) u_props (
	.mclk(mclk), .rstn(rstn), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
	.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
	.usb_evt(usb_evt), .usb_bus_reset(usb_bus_reset), .usb_bus_idle(usb_bus_idle),
	.tok_valid(tok_valid), .tok_accept(tok_accept), .tok_reject(tok_reject),
	.ep_req(ep_req), .ep_rdata(ep_rdata), .ep_selected(ep_selected), .usb_irq(usb_irq));

/* File: usbic_ep_bank.sv */
// usbic_ep_bank: behavioural per-endpoint register bank behind the selector.
// assumes forwarded accesses arrive as one-cycle rd/wr pulses.
`timescale 1ns/100ps
module usbic_ep_bank (
	// clock
	input wire logic mclk,
	// forwarded access
	input wire usbic_pkg::usbic_epreq_t ep_req,
	output logic [7:0] ep_rdata
);
	logic [7:0] mem [0:31]; // four registers per endpoint
	logic [4:0] ra = 5'h00; // last read index
	logic hold = 1'b0; // data still owed one more cycle
	initial begin
		for (int i = 0; i < 32; i++) mem[i] = 8'(i);
	end
	// store writes, remember reads for the hold cycle
	always @(posedge mclk) begin
		if (ep_req.wr) mem[{ep_req.ep[2:0], ep_req.regsel}] <= ep_req.wdata;
		if (ep_req.rd) ra <= {ep_req.ep[2:0], ep_req.regsel};
		hold <= ep_req.rd;
	end
	// outside the valid window the data is inverted so stale reads show up
	assign ep_rdata = ep_req.rd ? mem[{ep_req.ep[2:0], ep_req.regsel}] :
		(hold ? mem[ra] : ~mem[ra]);
endmodule

/* File: tb.sv */
// tb: self-checking bench for usbic_ctrl with an endpoint bank model.
// assumes a shortened suspend idle count of 20 cycles.
`timescale 1ns/100ps
module tb;
	logic mclk, rstn, ce, sfr_wr, sfr_rd, sfr_rvalid, usb_bus_reset, usb_bus_idle;
	logic tok_valid, tok_accept, tok_reject, usb_irq;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, ep_rdata, rd_val, d;
	logic [6:0] tok_addr, ta;
	logic [3:0] ep_selected;
	usbic_pkg::usbic_evt_t usb_evt;
	usbic_pkg::usbic_epreq_t ep_req;
	int miscompares = 0, n_checks = 0, cyc = 0, m_addr, bt;
	int m_ep [0:27]; // model of endpoint registers
	logic [7:0] regs [4] = '{8'hcf, 8'he2, 8'he3, 8'hd4};
	int bits [4] = '{5, 4, 3, 0};

	usbic_ctrl #(.IDLE_CYCLES(20)) u_dut (.mclk(mclk), .rstn(rstn), .ce(ce),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .usb_evt(usb_evt),
		.usb_bus_reset(usb_bus_reset), .usb_bus_idle(usb_bus_idle), .tok_valid(tok_valid),
		.tok_addr(tok_addr), .tok_accept(tok_accept), .tok_reject(tok_reject),
		.ep_req(ep_req), .ep_rdata(ep_rdata), .ep_selected(ep_selected), .usb_irq(usb_irq));
	usbic_ep_bank u_bank (.mclk(mclk), .ep_req(ep_req), .ep_rdata(ep_rdata));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		sfr_addr <= a;
		sfr_wdata <= v;
		sfr_wr <= 1'b1;
		@(posedge mclk);
		sfr_wr <= 1'b0;
	endtask
	// also drops a pending bus reset so a read can follow it directly
	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
		int i;
		@(posedge mclk);
		usb_bus_reset <= 1'b0;
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge mclk);
		sfr_rd <= 1'b0;
		#1;
		for (i = 0; i < 4 && sfr_rvalid !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		rd_val = (i < 4) ? sfr_rdata : 8'hxx;
		check(nm, rd_val, exp);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// hang guard, generous against a few hundred cycles of traffic
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		{rstn, sfr_wr, sfr_rd, usb_bus_reset, usb_bus_idle, tok_valid} = '0;
		{ce, sfr_addr, sfr_wdata, tok_addr, usb_evt} = {1'b1, 26'h0};
		void'($urandom(32'h34e1e67f));
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		rchk("mask_rst", 8'hbe, 8'h10);
		rchk("addr_rst", 8'hc6, 8'h00);
		rchk("sel_rst", 8'hc7, 8'h00);
		d = 8'($urandom());
		wr(8'hbe, d);
		rchk("mask", 8'hbe, d & 8'h39);
		rchk("unmapped", 8'h80, 8'h00);
		// each source: masked off stays quiet, enabled raises, zero mask drops
		for (int s = 0; s < 4; s++) begin
			bt = bits[s];
			wr(8'hbd, 8'h00);
			wr(8'hbe, 8'h39 & ~(8'h01 << bt));
			@(posedge mclk);
			if (s < 3) usb_evt <= usbic_pkg::usbic_evt_t'(3'b100 >> s);
			else usb_bus_idle <= 1'b1;
			repeat (s < 3 ? 1 : 23) @(posedge mclk);
			{usb_evt, usb_bus_idle} <= 4'h0;
			repeat (3) @(posedge mclk);
			#1 check("irq_masked", {7'h0, usb_irq}, 8'h00);
			rchk("flags", 8'hbd, 8'h01 << bt);
			wr(8'hbe, 8'h01 << bt);
			repeat (2) @(posedge mclk);
			#1 check("irq_on", {7'h0, usb_irq}, 8'h01);
			wr(8'hbe, 8'h00);
			repeat (2) @(posedge mclk);
			#1 check("irq_off", {7'h0, usb_irq}, 8'h00);
		end
		// address filter off then on, the first token always matching
		for (int f = 0; f < 2; f++) begin
			m_addr = $urandom_range(127, 0);
			wr(8'hc6, {f[0], 7'(m_addr)});
			rchk("addr", 8'hc6, {f[0], 7'(m_addr)});
			for (int i = 0; i < 6; i++) begin
				ta = (i == 0) ? 7'(m_addr) : 7'($urandom());
				@(posedge mclk);
				tok_valid <= 1'b1;
				tok_addr <= ta;
				@(posedge mclk);
				tok_valid <= 1'b0;
				#1 check("accept", {7'h0, tok_accept}, {7'h0, f == 0 || ta == 7'(m_addr)});
				check("reject", {7'h0, tok_reject}, {7'h0, f == 1 && ta != 7'(m_addr)});
			end
		end
		@(posedge mclk);
		usb_bus_reset <= 1'b1;
		rchk("addr_busrst", 8'hc6, 8'h80);
		// pass 0 writes every endpoint register, pass 1 reads them back
		for (int p = 0; p < 2; p++) begin
			for (int e = 0; e < 7; e++) begin
				wr(8'hc7, 8'(e));
				#1 check("ep_sel", {4'h0, ep_selected}, 8'(e));
				for (int r = 0; r < 4; r++) begin
					if (p == 0) begin
						d = 8'($urandom());
						if (e < 7) m_ep[e * 4 + r] = d;
						wr(regs[r], d);
					end else begin
						rchk("ep_reg", regs[r], e < 7 ? 8'(m_ep[e * 4 + r]) : 8'h00);
					end
				end
			end
		end
		tally_and_finish();
	end
endmodule
